/* File: ubg_pkg.sv */
// Purpose: Constants for the serial port mode and baud rate generator
// Assumes: Core clock is clk; one machine cycle per core clock
// Notes: Register addresses are byte addresses on the plain register port
`default_nettype none
package ubg_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h87;
  localparam logic [7:0] ADDR_TIMER_RUN = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
  localparam logic [7:0] ADDR_T1_RELOAD = 8'h8D;
  localparam logic [7:0] ADDR_SERIAL_CTRL = 8'h98;
  localparam logic [7:0] ADDR_SERIAL_BUF = 8'h99;
  localparam logic [7:0] ADDR_T2_CTRL = 8'hC8;
  localparam logic [7:0] ADDR_T2_RLD_LO = 8'hCA;
  localparam logic [7:0] ADDR_T2_RLD_HI = 8'hCB;
  localparam logic [7:0] ADDR_T2_CNT_LO = 8'hCC;
  localparam logic [7:0] ADDR_T2_CNT_HI = 8'hCD;
  // Field positions
  localparam int SC_MODE_HI = 7;
  localparam int SC_MODE_LO = 6;
  localparam int SC_RX_EN = 4;
  localparam int SC_RX_FLAG = 0;
  localparam int PC_DOUBLE = 7;
  localparam int TR_T1_RUN = 6;
  localparam int TM_T1_MODE_HI = 5;
  localparam int TM_T1_MODE_LO = 4;
  localparam logic [1:0] T1_AUTORELOAD = 2'h2;
  localparam int T2_FLAG = 7;
  localparam int T2_RCLK = 5;
  localparam int T2_TX_CLOCK_SOURCE_SELECT = 4;
  localparam int T2_RUN = 2;
  localparam int T2_CAP = 0;
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  // Timing
  localparam int CORE_HZ = 10_000_000;
  localparam int SHIFT_DIV = 12;
  localparam int FIX_DIV_SLOW = 32;
  localparam int FIX_DIV_FAST = 16;
  localparam int OVF_PER_BIT = 16;
  localparam int T2_BAUD_PRESCALE = 2;
  localparam logic [3:0] SHIFT_LAST = 4'(SHIFT_DIV - 1);
  localparam logic [4:0] FIX_LAST_SLOW = 5'(FIX_DIV_SLOW - 1);
  localparam logic [4:0] FIX_LAST_FAST = 5'(FIX_DIV_FAST - 1);
  localparam logic [3:0] DIV_LAST = 4'(OVF_PER_BIT - 1);
  localparam int STRAP_SETTLE = 2;
  // Serial port modes
  typedef enum logic [1:0] {SM_SHIFT, SM_UART8, SM_UART9_FIX, SM_UART9_VAR} ubg_mode_t;
endpackage : ubg_pkg
`default_nettype wire

/* File: ubg_baud_gen.sv */
// Purpose: Serial port mode control, transfer start and baud rate generation
// Assumes: rx_done and strobe_level come from logic on clk; rxd_pin and strobe pin are async
// Notes: Bit enables are one-cycle pulses at the selected bit rate
// Functional notes
// - Both mode-select bits set selects variable-rate 9-bit mode.
// - Variable 9-bit mode frames as fixed 9-bit mode, rate from timer.
// - Any write to the serial buffer starts a transmission.
// - Shift mode receives when receive flag clear and receive enabled.
// - Async modes receive on a start bit, only while receive enabled.
// - Shift mode clock is core clock divided by twelve.
// - Fixed 9-bit rate is core clock over 32, or 16 when doubled.
// - Variable modes take rate from Timer 1, Timer 2, or one each.
// - Timer 1 rate is 2^double/32 times its overflow rate.
// - Sixteen selected timer ticks make one serial bit: Timer 2 overflows, or Timer 1 overflows, every second one unless doubled.
// - Timer 2 counts every two clocks while a baud generator.
// - Transmit or receive clock select puts Timer 2 in baud mode.
// - Transmit and receive rates may differ at the same time.
// - Timer 2 rate is core clock over 32 times (65536 - reload).
// - Timer 2 has a count byte pair and a reload byte pair.
// - Program strobe pin is an input until sampled after reset release, then an output.
// - Strobe pin low at reset enters download mode, else normal run.
// - A machine cycle, Timer 1 step, is one core clock period.
// - Timer 2 overflow flag is not set while in baud mode.
// - In baud mode capture select is ignored, reload every overflow.
`default_nettype none
module ubg_baud_gen
  import ubg_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic rxd_pin,
  input wire logic rx_done,
  input wire logic strobe_level,
  input wire logic program_strobe_pin_in,
  output logic program_strobe_pin_out,
  output logic program_strobe_pin_oe,
  output logic download_mode,
  output logic nine_bit_frame,
  output logic [7:0] tx_data,
  output logic tx_start,
  output logic rx_start,
  output logic tx_bit_en,
  output logic rx_bit_en
);

  typedef struct packed {
    logic [7:0] scon;
    logic [7:0] serial_buffer_reg;
    logic [7:0] power_control_reg;
    logic [7:0] timer_mode_reg;
    logic [7:0] trun;
    logic [7:0] timer2_control_reg;
    logic [7:0] t1_cnt;
    logic [7:0] t1_rld;
    logic t1_half;
    logic [15:0] t2_cnt;
    logic [15:0] t2_rld;
    logic t2_pre;
    logic [3:0] shift_cnt;
    logic [4:0] fix_cnt;
    logic [3:0] tx_div;
    logic [3:0] rx_div;
    logic rxd_s1;
    logic rxd_s2;
    logic rxd_prev;
    logic rx_busy;
    logic ps_s1;
    logic ps_s2;
    logic [1:0] ps_wait;
    logic ps_done;
    logic dl_mode;
    logic ps_out;
    logic [7:0] rdata;
    logic tx_start;
    logic rx_start;
    logic tx_bit;
    logic rx_bit;
  } ubg_state_t;

  localparam ubg_state_t RESET_STATE = '{rxd_s1: 1'b1, rxd_s2: 1'b1, rxd_prev: 1'b1,
                                        ps_s1: 1'b1, ps_s2: 1'b1, ps_out: 1'b1,
                                        default: '0};

  function automatic ubg_mode_t mode_of(input logic hi, input logic lo);
    return ubg_mode_t'({hi, lo});
  endfunction : mode_of

  ubg_state_t q;
  ubg_state_t d;
  ubg_mode_t mode;
  logic t2_baud;
  logic dbl;
  logic t1_ovf;
  logic t1_tick;
  logic t2_step;
  logic t2_ovf;
  logic t2_flag_set;
  logic shift_tick;
  logic fix_tick;
  logic [4:0] fix_last;
  logic tx_src;
  logic rx_src;
  logic tx_div_tick;
  logic rx_div_tick;

  always_comb begin
    d = q;
    d.tx_start = 1'b0;
    d.rx_start = 1'b0;
    d.tx_bit = 1'b0;
    d.rx_bit = 1'b0;
    d.rdata = REG_RESET;
    mode = mode_of(q.scon[SC_MODE_HI], q.scon[SC_MODE_LO]);
    t2_baud = q.timer2_control_reg[T2_RCLK] | q.timer2_control_reg[T2_TX_CLOCK_SOURCE_SELECT];
    dbl = q.power_control_reg[PC_DOUBLE];
    d.rxd_s1 = rxd_pin;
    d.rxd_s2 = q.rxd_s1;
    d.rxd_prev = q.rxd_s2;
    d.ps_out = strobe_level;

    // Timer 1: 8-bit autoreload, one step per core clock
    t1_ovf = 1'b0;
    if (q.trun[TR_T1_RUN] && q.timer_mode_reg[TM_T1_MODE_HI:TM_T1_MODE_LO] == T1_AUTORELOAD) begin
      if (q.t1_cnt == 8'hFF) begin
        t1_ovf = 1'b1;
        d.t1_cnt = q.t1_rld;
      end else begin
        d.t1_cnt = q.t1_cnt + 8'h01;
      end
    end
    if (t1_ovf) begin
      d.t1_half = ~q.t1_half;
    end
    t1_tick = t1_ovf && (dbl || q.t1_half);

    // Timer 2: halved step rate and forced reload in baud mode
    t2_ovf = 1'b0;
    t2_flag_set = 1'b0;
    t2_step = q.timer2_control_reg[T2_RUN] && (!t2_baud || q.t2_pre);
    if (q.timer2_control_reg[T2_RUN]) begin
      d.t2_pre = ~q.t2_pre;
    end
    if (t2_step) begin
      if (q.t2_cnt == 16'hFFFF) begin
        t2_ovf = 1'b1;
        if (t2_baud || !q.timer2_control_reg[T2_CAP]) begin
          d.t2_cnt = q.t2_rld;
        end else begin
          d.t2_cnt = 16'h0000;
        end
        t2_flag_set = !t2_baud;
      end else begin
        d.t2_cnt = q.t2_cnt + 16'h0001;
      end
    end

    // Fixed dividers
    shift_tick = q.shift_cnt >= SHIFT_LAST;
    d.shift_cnt = shift_tick ? 4'h0 : q.shift_cnt + 4'h1;
    fix_last = dbl ? FIX_LAST_FAST : FIX_LAST_SLOW;
    fix_tick = q.fix_cnt >= fix_last;
    d.fix_cnt = fix_tick ? 5'h00 : q.fix_cnt + 5'h01;

    // Per-direction overflow dividers
    tx_src = q.timer2_control_reg[T2_TX_CLOCK_SOURCE_SELECT] ? t2_ovf : t1_tick;
    rx_src = q.timer2_control_reg[T2_RCLK] ? t2_ovf : t1_tick;
    tx_div_tick = tx_src && q.tx_div == DIV_LAST;
    rx_div_tick = rx_src && q.rx_div == DIV_LAST;
    if (tx_src) begin
      d.tx_div = q.tx_div + 4'h1;
    end
    if (rx_src) begin
      d.rx_div = q.rx_div + 4'h1;
    end

    unique case (mode)
      SM_SHIFT: begin
        d.tx_bit = shift_tick;
        d.rx_bit = shift_tick;
      end
      SM_UART9_FIX: begin
        d.tx_bit = fix_tick;
        d.rx_bit = fix_tick;
      end
      SM_UART8, SM_UART9_VAR: begin
        d.tx_bit = tx_div_tick;
        d.rx_bit = rx_div_tick;
      end
    endcase

    // Reception start
    if (!q.rx_busy && q.scon[SC_RX_EN]) begin
      if (mode == SM_SHIFT ? !q.scon[SC_RX_FLAG] : (q.rxd_prev && !q.rxd_s2)) begin
        d.rx_start = 1'b1;
        d.rx_busy = 1'b1;
      end
    end
    if (rx_done) begin
      d.rx_busy = 1'b0;
    end

    // Register writes
    if (bus_wr) begin
      case (bus_addr)
        ADDR_POWER_CTRL: d.power_control_reg = bus_wdata;
        ADDR_TIMER_RUN: d.trun = bus_wdata;
        ADDR_TIMER_MODE: d.timer_mode_reg = bus_wdata;
        ADDR_T1_RELOAD: d.t1_rld = bus_wdata;
        ADDR_SERIAL_CTRL: d.scon = bus_wdata;
        ADDR_SERIAL_BUF: begin
          d.serial_buffer_reg = bus_wdata;
          d.tx_start = 1'b1;
        end
        ADDR_T2_CTRL: d.timer2_control_reg = bus_wdata;
        ADDR_T2_RLD_LO: d.t2_rld[7:0] = bus_wdata;
        ADDR_T2_RLD_HI: d.t2_rld[15:8] = bus_wdata;
        ADDR_T2_CNT_LO: d.t2_cnt[7:0] = bus_wdata;
        ADDR_T2_CNT_HI: d.t2_cnt[15:8] = bus_wdata;
        default: ;
      endcase
    end
    // Hardware sets win over software clears
    if (rx_done) begin
      d.scon[SC_RX_FLAG] = 1'b1;
    end
    if (t2_flag_set) begin
      d.timer2_control_reg[T2_FLAG] = 1'b1;
    end

    // Register reads, data in the following cycle only
    if (bus_rd) begin
      case (bus_addr)
        ADDR_POWER_CTRL: d.rdata = q.power_control_reg;
        ADDR_TIMER_RUN: d.rdata = q.trun;
        ADDR_TIMER_MODE: d.rdata = q.timer_mode_reg;
        ADDR_T1_RELOAD: d.rdata = q.t1_rld;
        ADDR_SERIAL_CTRL: d.rdata = q.scon;
        ADDR_SERIAL_BUF: d.rdata = q.serial_buffer_reg;
        ADDR_T2_CTRL: d.rdata = q.timer2_control_reg;
        ADDR_T2_RLD_LO: d.rdata = q.t2_rld[7:0];
        ADDR_T2_RLD_HI: d.rdata = q.t2_rld[15:8];
        ADDR_T2_CNT_LO: d.rdata = q.t2_cnt[7:0];
        ADDR_T2_CNT_HI: d.rdata = q.t2_cnt[15:8];
        default: d.rdata = REG_RESET;
      endcase
    end

    // Strap: pin is an input until sampled after reset release
    if (!q.ps_done) begin
      d.ps_s1 = program_strobe_pin_in;
      d.ps_s2 = q.ps_s1;
      if (q.ps_wait == 2'(STRAP_SETTLE)) begin
        d.ps_done = 1'b1;
        d.dl_mode = !q.ps_s2;
      end else begin
        d.ps_wait = q.ps_wait + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  assign bus_rdata = q.rdata;
  assign program_strobe_pin_out = q.ps_out;
  assign program_strobe_pin_oe = q.ps_done;
  assign download_mode = q.dl_mode;
  assign nine_bit_frame = q.scon[SC_MODE_HI];
  assign tx_data = q.serial_buffer_reg;
  assign tx_start = q.tx_start;
  assign rx_start = q.rx_start;
  assign tx_bit_en = q.tx_bit;
  assign rx_bit_en = q.rx_bit;

  // Checks
  property p_mode3;
    @(posedge clk) disable iff (!nrst)
      (q.scon[SC_MODE_HI] && q.scon[SC_MODE_LO]) |-> (mode == SM_UART9_VAR) && nine_bit_frame;
  endproperty
  a_mode3: assert property (p_mode3) else $error("mode bits 11 not variable 9-bit");

  property p_var_rate;
    @(posedge clk) disable iff (!nrst)
      ($past(mode) == SM_UART9_VAR && !$past(q.timer2_control_reg[T2_TX_CLOCK_SOURCE_SELECT]) && tx_bit_en) |-> $past(t1_tick);
  endproperty
  a_var_rate: assert property (p_var_rate) else $error("mode 3 tx bit without timer tick");

  property p_tx_t2_rate;
    @(posedge clk) disable iff (!nrst)
      ($past(mode) inside {SM_UART8, SM_UART9_VAR} && $past(q.timer2_control_reg[T2_TX_CLOCK_SOURCE_SELECT]) && tx_bit_en)
        |-> $past(t2_ovf);
  endproperty
  a_tx_t2_rate: assert property (p_tx_t2_rate) else $error("tx not from timer 2");

  property p_rx_t1_rate;
    @(posedge clk) disable iff (!nrst)
      ($past(mode) inside {SM_UART8, SM_UART9_VAR} && !$past(q.timer2_control_reg[T2_RCLK]) && rx_bit_en)
        |-> $past(t1_tick);
  endproperty
  a_rx_t1_rate: assert property (p_rx_t1_rate) else $error("rx not from timer 1");

  property p_tx_start;
    @(posedge clk) disable iff (!nrst)
      (bus_wr && bus_addr == ADDR_SERIAL_BUF) |=> tx_start && tx_data == $past(bus_wdata);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("buffer write did not start tx");

  property p_rx_shift;
    @(posedge clk) disable iff (!nrst)
      (mode == SM_SHIFT && q.scon[SC_RX_EN] && !q.scon[SC_RX_FLAG] && !q.rx_busy) |=> rx_start;
  endproperty
  a_rx_shift: assert property (p_rx_shift) else $error("shift mode reception not started");

  property p_rx_async;
    @(posedge clk) disable iff (!nrst)
      (rx_start && $past(mode) != SM_SHIFT) |-> $past(q.scon[SC_RX_EN]) && $past(q.rxd_prev, 1)
        && !$past(q.rxd_s2);
  endproperty
  a_rx_async: assert property (p_rx_async) else $error("async reception without start bit");

  property p_shift_rate;
    @(posedge clk) disable iff (!nrst)
      ($past(mode) == SM_SHIFT && tx_bit_en) |-> $past(q.shift_cnt) == SHIFT_LAST;
  endproperty
  a_shift_rate: assert property (p_shift_rate) else $error("shift clock not divide by 12");

  property p_fix_rate;
    @(posedge clk) disable iff (!nrst)
      (tx_bit_en && $past(mode) == SM_UART9_FIX && $past(dbl) == $past(dbl, 2))
        |-> $past(q.fix_cnt) == ($past(dbl) ? FIX_LAST_FAST : FIX_LAST_SLOW);
  endproperty
  a_fix_rate: assert property (p_fix_rate) else $error("fixed 9-bit rate wrong");

  property p_t2_half;
    @(posedge clk) disable iff (!nrst)
      (t2_baud && q.timer2_control_reg[T2_RUN] && $past(t2_baud) && $past(q.timer2_control_reg[T2_RUN])
        && !$past(bus_wr) && !bus_wr && q.t2_cnt != $past(q.t2_cnt)) |=> $stable(q.t2_cnt);
  endproperty
  a_t2_half: assert property (p_t2_half) else $error("timer 2 stepped twice in a row");

  property p_no_flag;
    @(posedge clk) disable iff (!nrst)
      (t2_ovf && t2_baud && !q.timer2_control_reg[T2_FLAG] && !bus_wr) |=> !q.timer2_control_reg[T2_FLAG];
  endproperty
  a_no_flag: assert property (p_no_flag) else $error("overflow flag set in baud mode");

  property p_reload;
    @(posedge clk) disable iff (!nrst)
      (t2_ovf && t2_baud && !bus_wr) |=> q.t2_cnt == $past(q.t2_rld);
  endproperty
  a_reload: assert property (p_reload) else $error("baud overflow did not reload");

  property p_strap;
    @(posedge clk) disable iff (!nrst)
      $rose(q.ps_done) |-> program_strobe_pin_oe && download_mode == !$past(q.ps_s2);
  endproperty
  a_strap: assert property (p_strap) else $error("strap sample wrong");

  c_var_tx: cover property (@(posedge clk) disable iff (!nrst) mode == SM_UART9_VAR && tx_bit_en);
  c_t2_ovf: cover property (@(posedge clk) disable iff (!nrst) t2_ovf && t2_baud);
  c_rx_async: cover property (@(posedge clk) disable iff (!nrst) rx_start && mode == SM_UART8);
  c_dl: cover property (@(posedge clk) disable iff (!nrst) $rose(download_mode));

endmodule : ubg_baud_gen
`default_nettype wire

/* File: ubg_far_end.sv */
// Purpose: Far-end model: remote serial sender, receive shifter and strap jumper
// Assumes: Driven from clk; send is a one-cycle pulse
// Notes: Pin is pulled up unless the jumper is fitted
`default_nettype none
module ubg_far_end (
  input wire logic clk,
  input wire logic rx_start,
  input wire logic send,
  input wire logic jumper,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic rxd,
  output logic rx_done,
  output logic pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int low_left = 0;
  int busy_left = 0;
  // Jumper pulls low only when fitted
  assign pin_in = pin_oe ? pin_out : !jumper;
  always @(posedge clk) begin
    rx_done <= (busy_left == 1);
    if (busy_left > 0) begin
      busy_left <= busy_left - 1;
    end else if (rx_start) begin
      busy_left <= 30;
    end
    if (send && low_left == 0) begin
      low_left <= 16;
    end else if (low_left > 0) begin
      low_left <= low_left - 1;
    end
    rxd <= !(send || low_left > 1);
  end
endmodule : ubg_far_end
`default_nettype wire

/* File: tb_uart_baud_rate_generator.sv */
// Purpose: Self-checking bench for the serial mode and baud generator
// Assumes: 10 MHz clk; inputs change by NBA at rising edges
// Notes: Periods are measured between consecutive bit enables
`default_nettype none
module tb_uart_baud_rate_generator
  import ubg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, bus_wr = 0, bus_rd = 0, send = 0, jumper = 0, strobe_lvl = 1;
  logic [7:0] bus_addr = 0, bus_wdata = 0, bus_rdata, tx_data;
  logic rxd_pin, rx_done, ps_in, ps_out, ps_oe, download_mode, nine_bit_frame;
  logic tx_start, rx_start, tx_bit_en, rx_bit_en;
  int miscompares = 0, samples_checked = 0;
  always #50 clk = ~clk;
  ubg_baud_gen dut (.clk(clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rxd_pin(rxd_pin),
    .rx_done(rx_done), .strobe_level(strobe_lvl), .program_strobe_pin_in(ps_in),
    .program_strobe_pin_out(ps_out), .program_strobe_pin_oe(ps_oe),
    .download_mode(download_mode), .nine_bit_frame(nine_bit_frame), .tx_data(tx_data),
    .tx_start(tx_start), .rx_start(rx_start), .tx_bit_en(tx_bit_en), .rx_bit_en(rx_bit_en));
  ubg_far_end far (.clk(clk), .rx_start(rx_start), .send(send), .jumper(jumper),
    .pin_out(ps_out), .pin_oe(ps_oe), .rxd(rxd_pin), .rx_done(rx_done), .pin_in(ps_in));
  task automatic tally_and_finish;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask : rd
  function automatic logic pick(input int s);
    return s == 0 ? tx_bit_en : (s == 1 ? rx_bit_en : rx_start);
  endfunction : pick
  // Cycles until the chosen pulse; a bound that runs out ends the run if must is set
  task automatic wt(input int s, input int lim, input bit must, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (pick(s) !== 1'b1 && n < lim);
    if (must && pick(s) !== 1'b1) begin
      miscompares++;
      $display("unexpected wait %0d: expected pulse seen none", s);
      tally_and_finish();
    end
  endtask : wt
  task automatic per(input int s, input int e);
    int n;
    wt(s, 800, 1, n);
    wt(s, 800, 1, n);
    wt(s, 800, 1, n);
    chk("period", 16'(e), 16'(n));
  endtask : per
  task automatic rst;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("oe in reset", 0, ps_oe);
    chk("strobe in reset", 1, ps_out);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("oe", 1, ps_oe);
    chk("download", 16'(jumper), download_mode);
    chk("strobe out", 16'(strobe_lvl), ps_out);
  endtask : rst
  task automatic t_regs;
    logic [7:0] a [4] = '{ADDR_T2_RLD_LO, ADDR_T2_RLD_HI, ADDR_T2_CNT_LO, ADDR_T2_CNT_HI};
    logic [7:0] d;
    foreach (a[i]) begin
      rd(a[i], d);
      chk("reset value", 16'h0000, d);
      wr(a[i], 8'(8'hA0 + i));
      rd(a[i], d);
      chk("readback", 16'(8'hA0 + i), d);
    end
    rd(8'h01, d);
    chk("unmapped", 16'h0000, d);
  endtask : t_regs
  task automatic t_tx;
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_SERIAL_CTRL, 8'(m << 6));
      wr(ADDR_SERIAL_BUF, 8'(8'h5A + m));
      #1 chk("tx_start", 1, tx_start);
      chk("tx_data", 16'(8'h5A + m), tx_data);
      chk("nine_bit", 16'(m >> 1), nine_bit_frame);
      @(posedge clk);
      #1 chk("tx_start end", 0, tx_start);
    end
  endtask : t_tx
  task automatic t_shift;
    int n;
    logic [7:0] d;
    wr(ADDR_SERIAL_CTRL, 8'h10);
    wt(2, 20, 1, n);
    per(0, 12);
    per(1, 12);
    rd(ADDR_SERIAL_CTRL, d);
    chk("rx flag", 1, d[SC_RX_FLAG]);
    wt(2, 40, 0, n);
    chk("no rx while flag", 40, 16'(n));
    wr(ADDR_SERIAL_CTRL, 8'h10);
    wt(2, 20, 1, n);
  endtask : t_shift
  task automatic t_fixed;
    wr(ADDR_SERIAL_CTRL, 8'h80);
    per(0, 32);
    wr(ADDR_POWER_CTRL, 8'h80);
    per(0, 16);
    per(1, 16);
  endtask : t_fixed
  task automatic t_var;
    int n;
    logic [7:0] d;
    wr(ADDR_T1_RELOAD, 8'hFE);
    wr(ADDR_TIMER_MODE, 8'h20);
    wr(ADDR_TIMER_RUN, 8'h40);
    wr(ADDR_T2_RLD_LO, 8'hFE);
    wr(ADDR_T2_RLD_HI, 8'hFF);
    wr(ADDR_T2_CNT_LO, 8'hFE);
    wr(ADDR_T2_CNT_HI, 8'hFF);
    wr(ADDR_T2_CTRL, 8'h15);
    wr(ADDR_SERIAL_CTRL, 8'hC0);
    per(0, 64);
    per(1, 32);
    wr(ADDR_POWER_CTRL, 8'h00);
    per(1, 64);
    rd(ADDR_T2_CTRL, d);
    chk("t2 flag", 0, d[T2_FLAG]);
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    wt(2, 40, 0, n);
    chk("no rx when disabled", 40, 16'(n));
    wr(ADDR_SERIAL_CTRL, 8'hD0);
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    wt(2, 20, 1, n);
    wr(ADDR_SERIAL_CTRL, 8'h50);
    per(0, 64);
    per(1, 64);
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    wt(2, 20, 1, n);
  endtask : t_var
  initial begin
    rst();
    t_regs();
    t_tx();
    t_shift();
    t_fixed();
    t_var();
    jumper <= 1'b1;
    strobe_lvl <= 1'b0;
    rst();
    jumper <= 1'b0;
    strobe_lvl <= 1'b1;
    rst();
    tally_and_finish();
  end
endmodule : tb_uart_baud_rate_generator
`default_nettype wire
